// ===== pkg/astc_map.vh
`ifndef ASTC_MAP_VH
`define ASTC_MAP_VH

// Register byte offsets
`define ASTC_CTRL_OFS      12'h000
`define ASTC_STAT_OFS      12'h004
`define ASTC_RESULT_OFS    12'h008
`define ASTC_CMPMODE_OFS   12'h00C
`define ASTC_TIMER_OFS     12'h010
`define ASTC_CFG_OFS       12'h014

// Control register fields
`define ASTC_CTRL_CLKSEL_HI 7
`define ASTC_CTRL_CLKSEL_LO 6
`define ASTC_CTRL_CHLO_HI   5
`define ASTC_CTRL_CHLO_LO   3
`define ASTC_CTRL_GO        2
`define ASTC_CTRL_CH3       1
`define ASTC_CTRL_ON        0

// Status and config fields
`define ASTC_STAT_DONE      0
`define ASTC_CFG_INTREF     0
`define ASTC_CFG_IRQEN      1

// Reset values
`define ASTC_CTRL_RST       8'h00
`define ASTC_CMPMODE_RST    4'h0
`define ASTC_TIMER_RST      16'h0000

// Compare mode that routes the special event trigger here
`define ASTC_MODE_SPECIAL   4'hB

// Interval selection codes
`define ASTC_CLK_OSC2       2'h0
`define ASTC_CLK_OSC8       2'h1
`define ASTC_CLK_OSC32      2'h2
`define ASTC_CLK_RC         2'h3

// Timing
`define ASTC_CLK_PERIOD_NS  50
`define ASTC_HALF_OSC2      1
`define ASTC_HALF_OSC8      4
`define ASTC_HALF_OSC32     16
`define ASTC_RC_TAD_NS      4000
`define ASTC_RC_HALF_CYC    ((`ASTC_RC_TAD_NS / `ASTC_CLK_PERIOD_NS) / 2)
`define ASTC_INTREF_MULT    8
`define ASTC_CONV_TADS      13
`define ASTC_PHASES         4
`define ASTC_TRIG_PHASE     2'h1

`endif

// ===== src/astc_phase_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "astc_map.vh"

module astc_phase_gen (
  input  wire       core_clk_in,
  input  wire       rst_in,
  output wire       q2_out,
  output wire       cyc_end_out
);

  reg [1:0] phase_q;
  reg       q2_q;
  reg       end_q;

  // Four oscillator phases per instruction cycle
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      phase_q <= 2'h0;
      q2_q    <= 1'b0;
      end_q   <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      q2_q    <= (phase_q == (`ASTC_TRIG_PHASE - 2'h1));
      end_q   <= (phase_q == 2'h2);
    end
  end

  assign q2_out      = q2_q;
  assign cyc_end_out = end_q;

endmodule
`default_nettype wire

// ===== src/astc_tad_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "astc_map.vh"

module astc_tad_gen #(
  parameter CNT_W = 12
) (
  input  wire       core_clk_in,
  input  wire       rst_in,
  input  wire       run_in,
  input  wire [1:0] clk_sel_in,
  input  wire       int_ref_in,
  output wire       tad_rise_out,
  output wire       tad_fall_out
);

  localparam [CNT_W-1:0] HALF_OSC2  = `ASTC_HALF_OSC2;
  localparam [CNT_W-1:0] HALF_OSC8  = `ASTC_HALF_OSC8;
  localparam [CNT_W-1:0] HALF_OSC32 = `ASTC_HALF_OSC32;
  localparam [CNT_W-1:0] HALF_RC    = `ASTC_RC_HALF_CYC;
  localparam [CNT_W-1:0] REF_MULT   = `ASTC_INTREF_MULT;

  reg [CNT_W-1:0] half_base;
  reg [CNT_W-1:0] half_len;
  reg [CNT_W-1:0] cnt_q;
  reg             level_q;
  reg             rise_q;
  reg             fall_q;
  wire            wrap;

  // Half interval length in core clocks
  always @* begin
    case (clk_sel_in)
      `ASTC_CLK_OSC2:  half_base = HALF_OSC2;
      `ASTC_CLK_OSC8:  half_base = HALF_OSC8;
      `ASTC_CLK_OSC32: half_base = HALF_OSC32;
      default:         half_base = HALF_RC;
    endcase
    half_len = int_ref_in ? half_base * REF_MULT : half_base;
  end

  assign wrap = (cnt_q == half_len - 1'b1);

  always @(posedge core_clk_in) begin
    if (rst_in || !run_in) begin
      cnt_q   <= {CNT_W{1'b0}};
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      cnt_q   <= wrap ? {CNT_W{1'b0}} : cnt_q + 1'b1;
      level_q <= wrap ? ~level_q : level_q;
      rise_q  <= wrap & ~level_q;
      fall_q  <= wrap & level_q;
    end
  end

  assign tad_rise_out = rise_q;
  assign tad_fall_out = fall_q;

endmodule
`default_nettype wire

// ===== src/astc_top.v
`timescale 1ns/10ps
`default_nettype none
`include "astc_map.vh"

module astc_top #(
  parameter RES_W = 12,
  parameter TMR_W = 16
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  input  wire        special_trig_in,
  input  wire        cmp_in,
  output wire [3:0]  chan_out,
  output wire        conv_on_out,
  output wire        conv_go_out,
  output wire        conv_done_out
);

  localparam [3:0] LAST_IDX = `ASTC_CONV_TADS;
  localparam [3:0] FIN_IDX  = `ASTC_CONV_TADS - 1;

  reg  [1:0]       clk_sel_q;
  reg  [3:0]       chan_q;
  reg              go_q;
  reg              on_q;
  reg              done_q;
  reg  [3:0]       mode_q;
  reg              int_ref_q;
  reg              irq_en_q;
  reg  [TMR_W-1:0] timer_q;
  reg  [RES_W-1:0] res_q;
  reg  [RES_W-1:0] sar_q;
  reg  [RES_W-1:0] mask_q;
  reg  [3:0]       tad_idx_q;
  reg              run_q;
  reg              fin_q;
  reg              trig_pend_q;
  reg              cmp_meta_q;
  reg              cmp_q;
  reg              pready_q;
  reg              pslverr_q;
  reg  [31:0]      prdata_q;
  reg  [31:0]      rd_d;
  reg              hit_d;

  wire             q2;
  wire             cyc_end;
  wire             tad_rise;
  wire             tad_fall;
  wire             acc;
  wire             wr;
  wire             wr_ctrl;
  wire             wr_go;
  wire             wr_on;
  wire             trig_now;
  wire             trig_spec;
  wire             trig_fire;
  wire             sw_start;
  wire             sw_abort;
  wire             last_tad;

  astc_phase_gen u_phase (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .q2_out      (q2),
    .cyc_end_out (cyc_end)
  );

  astc_tad_gen u_tad (
    .core_clk_in  (core_clk_in),
    .rst_in       (rst_in),
    .run_in       (run_q),
    .clk_sel_in   (clk_sel_q),
    .int_ref_in   (int_ref_q),
    .tad_rise_out (tad_rise),
    .tad_fall_out (tad_fall)
  );

  // APB: one wait state, write and read take effect with pready high
  assign acc     = psel_in & penable_in & pready_q;
  assign wr      = acc & pwrite_in;
  assign wr_ctrl = wr & (paddr_in == `ASTC_CTRL_OFS);
  assign wr_go   = pwdata_in[`ASTC_CTRL_GO];
  assign wr_on   = pwdata_in[`ASTC_CTRL_ON];

  // Go only starts when converter was already on
  assign sw_start = wr_ctrl & wr_go & wr_on & on_q & ~go_q;
  // Clearing go or power while busy aborts
  assign sw_abort = wr_ctrl & go_q & (~wr_go | ~wr_on);

  // Trigger acted on in the second phase only
  assign trig_now  = trig_pend_q & q2;
  assign trig_spec = trig_now & (mode_q == `ASTC_MODE_SPECIAL);
  assign trig_fire = trig_spec & on_q & ~go_q;

  assign last_tad = (tad_idx_q == LAST_IDX);

  always @* begin
    hit_d = 1'b1;
    rd_d  = 32'h0000_0000;
    case (paddr_in)
      `ASTC_CTRL_OFS:
        rd_d[7:0] = {clk_sel_q, chan_q[2:0], go_q, chan_q[3], on_q};
      `ASTC_STAT_OFS:
        rd_d[`ASTC_STAT_DONE] = done_q;
      `ASTC_RESULT_OFS:
        rd_d[RES_W-1:0] = res_q;
      `ASTC_CMPMODE_OFS:
        rd_d[3:0] = mode_q;
      `ASTC_TIMER_OFS:
        rd_d[TMR_W-1:0] = timer_q;
      `ASTC_CFG_OFS:
        rd_d[1:0] = {irq_en_q, int_ref_q};
      default:
        hit_d = 1'b0;
    endcase
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel_in & penable_in & ~pready_q;
      pslverr_q <= psel_in & penable_in & ~pready_q & ~hit_d;
      if (psel_in & penable_in & ~pready_q & ~pwrite_in)
        prdata_q <= rd_d;
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  // Comparator from the analog side
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      cmp_meta_q <= 1'b0;
      cmp_q      <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_in;
      cmp_q      <= cmp_meta_q;
    end
  end

  // Trigger held until the next second phase
  always @(posedge core_clk_in) begin
    if (rst_in)
      trig_pend_q <= 1'b0;
    else if (trig_now)
      trig_pend_q <= special_trig_in;
    else if (special_trig_in)
      trig_pend_q <= 1'b1;
  end

  // Period timer, one count per instruction cycle
  always @(posedge core_clk_in) begin
    if (rst_in)
      timer_q <= `ASTC_TIMER_RST;
    else if (trig_spec)
      timer_q <= {TMR_W{1'b0}};
    else if (wr && paddr_in == `ASTC_TIMER_OFS)
      timer_q <= pwdata_in[TMR_W-1:0];
    else if (cyc_end)
      timer_q <= timer_q + 1'b1;
  end

  // Configuration registers
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      clk_sel_q <= 2'h0;
      chan_q    <= 4'h0;
      on_q      <= 1'b0;
      mode_q    <= `ASTC_CMPMODE_RST;
      int_ref_q <= 1'b0;
      irq_en_q  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        clk_sel_q <= pwdata_in[`ASTC_CTRL_CLKSEL_HI:`ASTC_CTRL_CLKSEL_LO];
        chan_q    <= {pwdata_in[`ASTC_CTRL_CH3], pwdata_in[`ASTC_CTRL_CHLO_HI:`ASTC_CTRL_CHLO_LO]};
        on_q      <= wr_on;
      end
      if (wr && paddr_in == `ASTC_CMPMODE_OFS)
        mode_q <= pwdata_in[3:0];
      if (wr && paddr_in == `ASTC_CFG_OFS) begin
        int_ref_q <= pwdata_in[`ASTC_CFG_INTREF];
        irq_en_q  <= pwdata_in[`ASTC_CFG_IRQEN];
      end
    end
  end

  // Conversion sequencing and successive approximation
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      go_q      <= 1'b0;
      run_q     <= 1'b0;
      fin_q     <= 1'b0;
      done_q    <= 1'b0;
      tad_idx_q <= 4'h0;
      sar_q     <= {RES_W{1'b0}};
      mask_q    <= {RES_W{1'b0}};
      res_q     <= {RES_W{1'b0}};
    end else begin
      if (wr && paddr_in == `ASTC_STAT_OFS && pwdata_in[`ASTC_STAT_DONE])
        done_q <= 1'b0;
      if (sw_start || trig_fire) begin
        go_q      <= 1'b1;
        run_q     <= 1'b1;
        fin_q     <= 1'b0;
        tad_idx_q <= 4'h0;
        sar_q     <= {RES_W{1'b0}};
        mask_q    <= {RES_W{1'b0}};
      end else if (sw_abort) begin
        go_q   <= 1'b0;
        run_q  <= 1'b0;
        res_q  <= sar_q & ~mask_q;
        mask_q <= {RES_W{1'b0}};
      end else if (wr_ctrl && wr_go && !go_q) begin
        go_q <= 1'b0;
      end else if (run_q && tad_rise && !fin_q) begin
        tad_idx_q <= tad_idx_q + 4'h1;
        if (mask_q != {RES_W{1'b0}} && !cmp_q)
          sar_q <= (sar_q & ~mask_q) | (mask_q >> 1);
        else if (tad_idx_q == 4'h0)
          sar_q <= {1'b1, {(RES_W-1){1'b0}}};
        else
          sar_q <= sar_q | (mask_q >> 1);
        mask_q <= (tad_idx_q == 4'h0) ? {1'b1, {(RES_W-1){1'b0}}} : (mask_q >> 1);
        if (tad_idx_q == FIN_IDX) begin
          fin_q  <= 1'b1;
          done_q <= 1'b1;
          res_q  <= (!cmp_q) ? (sar_q & ~mask_q) : sar_q;
        end
      end else if (run_q && tad_fall && fin_q && last_tad) begin
        go_q  <= 1'b0;
        run_q <= 1'b0;
        fin_q <= 1'b0;
      end
    end
  end

  assign prdata_out    = prdata_q;
  assign pready_out    = pready_q;
  assign pslverr_out   = pslverr_q;
  assign chan_out      = chan_q;
  assign conv_on_out   = on_q;
  assign conv_go_out   = go_q;
  assign conv_done_out = done_q;

endmodule
`default_nettype wire

// ===== verification/astc_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "astc_map.vh"
module astc_chk (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        special_trig_in,
  input wire logic        cmp_in,
  input wire logic [3:0]  chan_out,
  input wire logic        conv_on_out,
  input wire logic        conv_go_out,
  input wire logic        conv_done_out
);
  wire acc = psel_in && penable_in && pready_out && pwrite_in;
  wire wr_ctrl = acc && paddr_in == `ASTC_CTRL_OFS;
  wire wr_stat = acc && paddr_in == `ASTC_STAT_OFS;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_go_start;
    $rose(conv_go_out);
  endsequence
  sequence s_done_first;
    $rose(conv_done_out) && conv_go_out;
  endsequence
  a_ctrl_fields: assert property (
    wr_ctrl |=> chan_out == {$past(pwdata_in[1]), $past(pwdata_in[5:3])} && conv_on_out == $past(pwdata_in[0]))
    else $error("control fields not applied");
  a_same_write: assert property (
    wr_ctrl && !conv_on_out && pwdata_in[2] |=> !conv_go_out) else $error("go set with power-on");
  a_go_rise_on: assert property (
    s_go_start |-> $past(conv_on_out)) else $error("go rose while off");
  a_go_min_len: assert property (
    s_go_start |=> (!$rose(conv_done_out)) [*8]) else $error("conversion ended too soon");
  a_done_go: assert property (
    $rose(conv_done_out) |-> $past(conv_go_out)) else $error("done without conversion");
  a_go_fall: assert property (
    s_done_first |-> ##[1:400] !conv_go_out) else $error("go did not clear after done");
  a_done_sticky: assert property (
    conv_done_out && !wr_stat |=> conv_done_out) else $error("done dropped by itself");
  a_stat_clear: assert property (
    wr_stat && pwdata_in[0] && !conv_go_out |=> !conv_done_out) else $error("done not cleared");
endmodule
`default_nettype wire

// ===== verification/astc_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none
module astc_cmp_model (
  input  wire logic [3:0] chan_in,
  output logic            cmp_out
);
  // Odd channels sit above every trial level, even ones below
  assign cmp_out = chan_in[0];
endmodule
`default_nettype wire

// ===== verification/astc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module astc_top_tb;
  logic        core_clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, special_trig_in = 0;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd, seed;
  logic        pready_out, pslverr_out, cmp_w, conv_on_out, conv_go_out, conv_done_out, er;
  logic [3:0]  chan_out, ch;
  int          error_cnt = 0, num_checks = 0, n, k;
  int          half_tab [4] = '{1, 4, 16, 40};
  logic [31:0] exp_q [$];
  // 10 us: settling plus charging plus the hot-side term
  localparam int ACQ_CYC = 200;
  astc_top astc_top_i (.core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .special_trig_in, .cmp_in(cmp_w), .chan_out, .conv_on_out,
    .conv_go_out, .conv_done_out);
  astc_cmp_model astc_cmp_model_i (.chan_in(chan_out), .cmp_out(cmp_w));
  initial forever #25 core_clk_in = ~core_clk_in;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task tmo;
    error_cnt++;
    $display("wrong value at %0t: wait timed out", $time);
    final_report;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge core_clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1;
    do begin
      @(posedge core_clk_in);
      i++;
    end while (pready_out !== 1'b1 && i < 20);
    if (pready_out !== 1'b1) tmo;
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask
  task wait_go_low(output int cyc);
    cyc = 0;
    do begin
      @(posedge core_clk_in);
      cyc++;
    end while (conv_go_out !== 1'b0 && cyc < 20000);
    if (conv_go_out !== 1'b0) tmo;
  endtask
  task conv(input int s, input logic iref);
    int t, cyc;
    ch = seed[3:0];
    seed = xs(seed);
    t = 2 * half_tab[s] * (iref ? 8 : 1);
    exp_q.push_back(ch[0] ? 32'hFFF : 32'h0);
    apb(1, 12'h014, {31'h0, iref});
    apb(1, 12'h000, {24'h0, s[1:0], ch[2:0], 1'b0, ch[3], 1'b1});
    repeat (ACQ_CYC) @(posedge core_clk_in);
    apb(1, 12'h000, {24'h0, s[1:0], ch[2:0], 1'b1, ch[3], 1'b1});
    wait_go_low(cyc);
    check(cyc >= 13 * t && cyc <= 14 * t + 4, 1);
    check({31'h0, conv_done_out}, 1);
    check({28'h0, chan_out}, {28'h0, ch});
    apb(0, 12'h008, 0);
    check(rd, exp_q.pop_front());
    apb(1, 12'h004, 1);
    apb(0, 12'h004, 0);
    check(rd, 0);
  endtask
  initial begin
    seed = 32'h42505675;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 0;
    apb(0, 12'h000, 0);
    check(rd, 0);
    apb(0, 12'h018, 0);
    check({31'h0, er}, 1);
    apb(1, 12'h000, 32'h05);
    apb(0, 12'h000, 0);
    check(rd, 32'h01);
    apb(1, 12'h000, 32'hC1);
    apb(0, 12'h000, 0);
    check(rd, 32'hC1);
    for (k = 0; k < 8; k++) conv(k % 4, k / 4);
    apb(1, 12'h014, 0);
    apb(1, 12'h000, 32'h89);
    repeat (ACQ_CYC) @(posedge core_clk_in);
    apb(1, 12'h000, 32'h8D);
    repeat (192) @(posedge core_clk_in);
    apb(1, 12'h000, 32'h89);
    apb(0, 12'h008, 0);
    check(rd & 32'h801, 32'h800);
    // Trigger cases: on and armed, off and armed, on but not armed
    for (k = 0; k < 3; k++) begin
      apb(1, 12'h000, {31'h4, k != 1});
      apb(1, 12'h00C, k == 2 ? 32'h0 : 32'hB);
      apb(1, 12'h010, 32'hFFF0);
      repeat (ACQ_CYC) @(posedge core_clk_in);
      special_trig_in <= 1;
      @(posedge core_clk_in);
      special_trig_in <= 0;
      repeat (8) @(posedge core_clk_in);
      check({31'h0, conv_go_out}, k == 0);
      if (k < 2) begin
        apb(0, 12'h010, 0);
        check(rd < 16, 1);
      end
      wait_go_low(n);
    end
    final_report;
  end
endmodule
bind astc_top astc_chk astc_chk_i (.core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .special_trig_in, .cmp_in, .chan_out, .conv_on_out,
  .conv_go_out, .conv_done_out);
`default_nettype wire
